// file: src/aorc_top.sv
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module aorc_top
   import aorc_pkg::*;
(
   // Clock and reset
   input  wire logic            core_clk_i,
   input  wire logic            reset_n_i,
   // Wishbone slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   // Converter drive
   output aorc_chan_out_t       ch2_out_o,
   output aorc_chan_out_t       ch3_out_o
);

   // Range table lookup
   function automatic aorc_range_t range_of(input logic [7:0] code);
      aorc_range_t r;
      r = '{valid: 1'b1, current: 1'b0, lo: LIM_LO_27K, hi: LIM_HI_27K};
      case (code)
         FC_V10_16K:  begin r.lo = LIM_LO_16K;  r.hi = LIM_HI_16K; end
         FC_V15_16K:  begin r.lo = LIM_LO_U16K; r.hi = LIM_HI_16K; end
         FC_V010_16K: begin r.lo = LIM_ZERO;    r.hi = LIM_HI_16K; end
         FC_V10_27K:  begin r.lo = LIM_LO_27K;  r.hi = LIM_HI_27K; end
         FC_V15_27K:  begin r.lo = LIM_LO_U27K; r.hi = LIM_HI_27K; end
         FC_V010_27K: begin r.lo = LIM_ZERO;    r.hi = LIM_HI_27K; end
         FC_A20_16K: begin
            r.current = 1'b1;
            r.lo      = LIM_LO_16K;
            r.hi      = LIM_HI_16K;
         end
         FC_A420_16K: begin
            r.current = 1'b1;
            r.lo      = LIM_LO_U16K;
            r.hi      = LIM_HI_16K;
         end
         FC_A020_16K: begin
            r.current = 1'b1;
            r.lo      = LIM_ZERO;
            r.hi      = LIM_HI_16K;
         end
         FC_A20_27K: begin
            r.current = 1'b1;
         end
         FC_A420_27K: begin
            r.current = 1'b1;
            r.lo      = LIM_LO_U27K;
         end
         FC_A020_27K: begin
            r.current = 1'b1;
            r.lo      = LIM_ZERO;
         end
         default: r.valid = 1'b0;
      endcase
      return r;
   endfunction

   // Bus handshake and per-channel state
   logic                      ack_reg;
   logic [31:0]               rdata_reg;
   logic [7:0]                code_reg   [NUM_CH];
   logic [7:0]                stored_reg [NUM_CH];
   logic signed [15:0]        value_reg  [NUM_CH];
   logic                      err_reg    [NUM_CH];
   aorc_chan_out_t            out_reg    [NUM_CH];
   logic                      req;
   logic                      wr_take;
   logic                      code_wr    [NUM_CH];
   logic                      value_wr   [NUM_CH];
   logic                      err_clr    [NUM_CH];
   aorc_range_t               wr_rng;
   aorc_range_t               act_rng    [NUM_CH];
   logic                      oor        [NUM_CH];
   logic [15:0]               legacy     [NUM_CH];
   logic [31:0]               rdata_next;

   assign req     = wb_cyc_i && wb_stb_i;
   assign wr_take = req && wb_we_i && ack_reg;
   assign wr_rng  = range_of(wb_dat_i[7:0]);

   // Acknowledge one cycle after request, drop the cycle after
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req && !ack_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         // Write decode for this channel
         assign code_wr[g]  = wr_take && wb_sel_i[0] &&
                              (wb_adr_i == (g == 0 ? OFS_CODE2 : OFS_CODE3));
         assign value_wr[g] = wr_take &&
                              (wb_adr_i == (g == 0 ? OFS_VALUE2 : OFS_VALUE3));
         assign err_clr[g]  = wr_take && wb_adr_i == OFS_STATUS &&
                              wb_sel_i[g] && wb_dat_i[g*STAT_CH_STRIDE + STAT_ERR_BIT];
         assign act_rng[g]  = range_of(code_reg[g]);
         assign oor[g]      = (value_reg[g] < act_rng[g].lo) ||
                              (value_reg[g] > act_rng[g].hi);

         // Legacy word: flags low, magnitude, sign high
         always_comb begin
            logic [15:0] mag;
            mag = value_reg[g][15] ? 16'(-value_reg[g]) : value_reg[g];
            legacy[g]               = {1'b0, mag[14:3], 3'h0};
            legacy[g][LEG_OVR_BIT]  = oor[g];
            legacy[g][LEG_ERR_BIT]  = err_reg[g];
            legacy[g][LEG_ACT_BIT]  = 1'b0;
            legacy[g][LEG_SIGN_BIT] = value_reg[g][15];
         end

         // Active and stored function codes
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               code_reg[g]   <= RST_CODE;
               stored_reg[g] <= RST_CODE;
            end else if (code_wr[g]) begin
               if (wb_dat_i[7:0] == FC_KEEP) begin
                  code_reg[g] <= stored_reg[g];
               end else if (wb_dat_i[7:0] == FC_OFF || wr_rng.valid) begin
                  code_reg[g]   <= wb_dat_i[7:0];
                  stored_reg[g] <= wb_dat_i[7:0];
               end
            end
         end

         // Output value written by software
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               value_reg[g] <= RST_VALUE;
            end else if (value_wr[g]) begin
               if (wb_sel_i[0]) value_reg[g][7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) value_reg[g][15:8] <= wb_dat_i[15:8];
            end
         end

         // Invalid code flag, set wins over clear
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               err_reg[g] <= 1'b0;
            end else if (code_wr[g] && !wr_rng.valid &&
                         wb_dat_i[7:0] != FC_KEEP && wb_dat_i[7:0] != FC_OFF) begin
               err_reg[g] <= 1'b1;
            end else if (err_clr[g]) begin
               err_reg[g] <= 1'b0;
            end
         end

         // Converter drive, zero when off or out of range
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               out_reg[g] <= '{active: 1'b1, current: 1'b0, code: RST_CODE,
                               value: RST_VALUE};
            end else begin
               out_reg[g].active  <= code_reg[g] != FC_OFF;
               out_reg[g].current <= act_rng[g].current;
               out_reg[g].code    <= code_reg[g];
               out_reg[g].value   <= (code_reg[g] == FC_OFF || oor[g]) ?
                                     RST_VALUE : value_reg[g];
            end
         end
      end
   endgenerate

   // Read mux, unmapped addresses read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (wb_adr_i)
         OFS_CODE2:  rdata_next[7:0]  = code_reg[0];
         OFS_CODE3:  rdata_next[7:0]  = code_reg[1];
         OFS_VALUE2: rdata_next[15:0] = value_reg[0];
         OFS_VALUE3: rdata_next[15:0] = value_reg[1];
         OFS_STATUS: begin
            for (int c = 0; c < NUM_CH; c++) begin
               rdata_next[c*STAT_CH_STRIDE + STAT_OVR_BIT] = oor[c];
               rdata_next[c*STAT_CH_STRIDE + STAT_ERR_BIT] = err_reg[c];
               rdata_next[c*STAT_CH_STRIDE + STAT_OFF_BIT] = code_reg[c] == FC_OFF;
            end
         end
         OFS_LEGCY2: rdata_next[15:0] = legacy[0];
         OFS_LEGCY3: rdata_next[15:0] = legacy[1];
         OFS_STORED: rdata_next[15:0] = {stored_reg[1], stored_reg[0]};
         default:    rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data captured with the request, held through ack
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req && !ack_reg) begin
         rdata_reg <= rdata_next;
      end
   end

   assign wb_ack_o  = ack_reg;
   assign wb_dat_o  = rdata_reg;
   assign ch2_out_o = out_reg[0];
   assign ch3_out_o = out_reg[1];

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_reset_range_code: assert property (
      $rose(reset_n_i) |-> code_reg[0] == FC_V10_27K && code_reg[1] == FC_V10_27K)
      else $error("channel not at default range after reset");

   chk_chan_code_sep: assert property (
      code_wr[0] && !code_wr[1] |=> $stable(code_reg[1]))
      else $error("code write to one channel changed the other");

   chk_keep_stored: assert property (
      code_wr[0] && wb_dat_i[7:0] == FC_KEEP |=> code_reg[0] == $past(stored_reg[0])
      && $stable(stored_reg[0]))
      else $error("keep code altered stored setting");

   chk_off_zero_out: assert property (
      code_wr[0] && wb_dat_i[7:0] == FC_OFF |-> ##2 !ch2_out_o.active
      && ch2_out_o.value == 16'h0000)
      else $error("channel not off two cycles after off code");

   chk_oor_zero_out: assert property (
      oor[0] && $stable(value_reg[0]) |=> ch2_out_o.value == 16'h0000)
      else $error("out-of-range value reached the converter");

   chk_inrange_pass: assert property (
      code_reg[0] == FC_V10_27K && value_reg[0] == LIM_LO_27K
      |=> ch2_out_o.value == LIM_LO_27K)
      else $error("underdrive end not passed");

   chk_ovr_limit16k: assert property (
      code_reg[1] == FC_V10_16K && value_reg[1] == 16'sd20481 |-> oor[1])
      else $error("value above 20480 not flagged");

   chk_legacy_flags: assert property (
      legacy[0][LEG_ACT_BIT] == 1'b0 && legacy[0][LEG_OVR_BIT] == oor[0])
      else $error("legacy flag bits wrong");

   chk_legacy_sign: assert property (
      legacy[1][LEG_SIGN_BIT] == (value_reg[1] < 0))
      else $error("legacy sign bit wrong");

   chk_bad_code_kept: assert property (
      code_wr[0] && !wr_rng.valid && wb_dat_i[7:0] != FC_KEEP && wb_dat_i[7:0] != FC_OFF
      |=> $stable(code_reg[0]) ##1 ch2_out_o.code == $past(code_reg[0], 2))
      else $error("invalid code changed range");

   chk_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   cov_off_code:  cover property (code_wr[0] && wb_dat_i[7:0] == FC_OFF);
   cov_keep_code: cover property (code_wr[1] && wb_dat_i[7:0] == FC_KEEP);
   cov_oor_hit:   cover property (oor[0] ##1 ch2_out_o.value == 16'h0000);
   cov_bad_code:  cover property (err_reg[1]);

endmodule

// file: src/aorc_pkg.sv
package aorc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CODE2  = 8'h00;
   localparam logic [7:0] OFS_CODE3  = 8'h04;
   localparam logic [7:0] OFS_VALUE2 = 8'h08;
   localparam logic [7:0] OFS_VALUE3 = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_LEGCY2 = 8'h14;
   localparam logic [7:0] OFS_LEGCY3 = 8'h18;
   localparam logic [7:0] OFS_STORED = 8'h1C;

   // Status field positions, channel 3 sits STAT_CH_STRIDE bits higher
   localparam int STAT_OVR_BIT   = 0;
   localparam int STAT_ERR_BIT   = 1;
   localparam int STAT_OFF_BIT   = 2;
   localparam int STAT_CH_STRIDE = 8;

   // Legacy word field positions
   localparam int LEG_OVR_BIT  = 0;
   localparam int LEG_ERR_BIT  = 1;
   localparam int LEG_ACT_BIT  = 2;
   localparam int LEG_SIGN_BIT = 15;

   // Function codes
   localparam logic [7:0] FC_KEEP    = 8'h00;
   localparam logic [7:0] FC_V10_16K = 8'h01;
   localparam logic [7:0] FC_V15_16K = 8'h02;
   localparam logic [7:0] FC_A20_16K = 8'h03;
   localparam logic [7:0] FC_A420_16K = 8'h04;
   localparam logic [7:0] FC_V010_16K = 8'h05;
   localparam logic [7:0] FC_A020_16K = 8'h06;
   localparam logic [7:0] FC_V10_27K = 8'h09;
   localparam logic [7:0] FC_V15_27K = 8'h0A;
   localparam logic [7:0] FC_A20_27K = 8'h0B;
   localparam logic [7:0] FC_A420_27K = 8'h0C;
   localparam logic [7:0] FC_V010_27K = 8'h0D;
   localparam logic [7:0] FC_A020_27K = 8'h0E;
   localparam logic [7:0] FC_OFF     = 8'hFF;

   // Reset values
   localparam logic [7:0]  RST_CODE  = FC_V10_27K;
   localparam logic [15:0] RST_VALUE = 16'h0000;

   // Range limits (ends of overdrive and underdrive regions)
   localparam logic signed [15:0] LIM_HI_16K  = 16'sd20480;
   localparam logic signed [15:0] LIM_LO_16K  = -16'sd20480;
   localparam logic signed [15:0] LIM_LO_U16K = -16'sd4096;
   localparam logic signed [15:0] LIM_HI_27K  = 16'sd32511;
   localparam logic signed [15:0] LIM_LO_27K  = -16'sd32512;
   localparam logic signed [15:0] LIM_LO_U27K = -16'sd6912;
   localparam logic signed [15:0] LIM_ZERO    = 16'sd0;

   localparam int NUM_CH = 2;

   // Range lookup result
   typedef struct packed {
      logic                valid;
      logic                current;
      logic signed [15:0]  lo;
      logic signed [15:0]  hi;
   } aorc_range_t;

   // Per-channel converter drive
   typedef struct packed {
      logic                active;
      logic                current;
      logic [7:0]          code;
      logic signed [15:0]  value;
   } aorc_chan_out_t;

endpackage

// file: tb/aorc_host_model.sv
`timescale 1ns/1ps
module aorc_host_model (
   // Clock
   input  wire logic        core_clk_i,
   // Answer from the block
   input  wire logic        wb_ack_i,
   input  wire logic [31:0] wb_dat_i,
   // Request to the block
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic [7:0]       wb_adr_o,
   output logic [3:0]       wb_sel_o,
   output logic [31:0]      wb_dat_o
);
   // Idle bus at time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'hFF;
      wb_sel_o = 4'hF;
      wb_dat_o = 32'hA5A5A5A5;
   end

   // One classic cycle, request held until ack is sampled high
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] wdat, output logic [31:0] rdat);
      @(posedge core_clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= adr;
      wb_sel_o <= sel;
      wb_dat_o <= wdat;
      do @(posedge core_clk_i); while (wb_ack_i !== 1'b1);
      rdat = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
      wb_adr_o <= ~adr;   // Released lines never show the last request
      wb_sel_o <= ~sel;
      wb_dat_o <= ~wdat;
   endtask
endmodule

// file: tb/test_aorc_top.sv
`timescale 1ns/1ps
module test_aorc_top;
   import aorc_pkg::*;
   logic            core_clk_i = 1'b0;
   logic            reset_n_i  = 1'b0;
   logic            wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0]      wb_adr;
   logic [3:0]      wb_sel;
   logic [31:0]     wb_wdat, wb_rdat, rd_v, o, x;
   aorc_chan_out_t  ch2_out, ch3_out;
   int              failures = 0;
   int              check_count = 0;
   int              cycles = 0;
   logic [7:0]      codes [12] = '{8'h01, 8'h02, 8'h05, 8'h09, 8'h0A, 8'h0D,
                                   8'h03, 8'h04, 8'h06, 8'h0B, 8'h0C, 8'h0E};
   logic [15:0]     lo_t [6] = '{16'hB000, 16'hF000, 16'h0000, 16'h8100, 16'hE500, 16'h0000};
   logic [15:0]     hi_t [6] = '{16'h5000, 16'h5000, 16'h5000, 16'h7EFF, 16'h7EFF, 16'h7EFF};
   logic [7:0]      bad_codes [5] = '{8'h07, 8'h08, 8'h0F, 8'h10, 8'hFE};

   // Clock and device
   always #5 core_clk_i = ~core_clk_i;
   aorc_top i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .ch2_out_o(ch2_out), .ch3_out_o(ch3_out));
   aorc_host_model i_host (.core_clk_i(core_clk_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat),
      .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
      .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat));

   // Shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrs(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] dummy;
      i_host.wb_cycle(1'b1, adr, s, d, dummy);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      wrs(adr, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] adr, output logic [31:0] d);
      i_host.wb_cycle(1'b0, adr, 4'hF, 32'h00000000, d);
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask
   function automatic logic [31:0] chan(input int ch);
      return (ch == 0) ? {6'h00, ch2_out} : {6'h00, ch3_out};
   endfunction
   function automatic logic [31:0] mk(input logic a, input logic c, input logic [7:0] f,
                                      input logic [15:0] v);
      return {6'h00, a, c, f, v};
   endfunction

   // Both channels start in the bipolar range with the wide scaling
   task automatic t_reset();
      #1;
      check(chan(0), mk(1'b1, 1'b0, 8'h09, 16'h0000));
      check(chan(1), mk(1'b1, 1'b0, 8'h09, 16'h0000));
      rd(OFS_CODE2, rd_v);
      check(rd_v, 32'h00000009);
   endtask

   // Every range code on each channel, values at and just past both ends
   task automatic t_ranges();
      logic [15:0] v;
      logic [7:0]  other;
      for (int ch = 0; ch < 2; ch++) begin
         other = (ch == 0) ? 8'h09 : 8'h0E;
         for (int i = 0; i < 12; i++) begin
            wr((ch == 0) ? OFS_CODE2 : OFS_CODE3, {24'h0, codes[i]});
            for (int j = 0; j < 4; j++) begin
               v = (j < 2) ? hi_t[i % 6] + 16'(j) : lo_t[i % 6] - 16'(j - 2);
               wr((ch == 0) ? OFS_VALUE2 : OFS_VALUE3, {16'h0, v});
               settle();
               o = chan(ch);
               x = mk(1'b1, i >= 6, codes[i], (j % 2 == 1) ? 16'h0000 : v);
               check(o, x);
               o = chan(1 - ch);
               check({24'h0, o[23:16]}, {24'h0, other});
            end
         end
      end
   endtask

   // Keep code and switch-off code on channel 2
   task automatic t_keep_off();
      wr(OFS_CODE2, 32'h00000005);
      wr(OFS_CODE2, 32'h00000000);
      wr(OFS_VALUE2, 32'h00000100);
      settle();
      check(chan(0), mk(1'b1, 1'b0, 8'h05, 16'h0100));
      rd(OFS_STORED, rd_v);
      check(rd_v, 32'h00000E05);
      wr(OFS_CODE2, 32'h000000FF);
      settle();
      check(chan(0) & 32'h02FFFFFF, 32'h00FF0000);
      wr(OFS_CODE2, 32'h00000000);
      settle();
      check(chan(0) & 32'h02FFFFFF, 32'h00FF0000);
      rd(OFS_STATUS, rd_v);
      check({31'h0, rd_v[STAT_OFF_BIT]}, 32'h00000001);
   endtask

   // Unlisted codes are refused, then the legacy word is read back
   task automatic t_invalid_legacy();
      wr(OFS_CODE2, 32'h00000009);
      foreach (bad_codes[k]) begin
         wr(OFS_CODE2, {24'h0, bad_codes[k]});
         rd(OFS_CODE2, rd_v);
         check(rd_v, 32'h00000009);
      end
      rd(OFS_STATUS, rd_v);
      check({31'h0, rd_v[STAT_ERR_BIT]}, 32'h00000001);
      wr(OFS_VALUE2, 32'h0000FFF8);
      rd(OFS_LEGCY2, rd_v);
      check(rd_v, 32'h0000800A);
      wr(OFS_VALUE2, 32'h00007EFF);
      rd(OFS_LEGCY2, rd_v);
      check(rd_v, 32'h00007EFA);
      wr(OFS_CODE2, 32'h00000001);
      wr(OFS_VALUE2, 32'h00005001);
      rd(OFS_LEGCY2, rd_v);
      check(rd_v & 32'h000000FF, 32'h00000003);
      // Clearing the other lane leaves the flag, own lane clears it
      wrs(OFS_STATUS, 32'h00000002, 4'h2);
      rd(OFS_STATUS, rd_v);
      check({31'h0, rd_v[STAT_ERR_BIT]}, 32'h00000001);
      wrs(OFS_STATUS, 32'h00000002, 4'h1);
      rd(OFS_LEGCY2, rd_v);
      check(rd_v & 32'h000000FF, 32'h00000001);
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      $display("failures=%0d checks=%0d", failures, check_count);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_ranges();
      t_keep_off();
      t_invalid_legacy();
      report_and_stop();
   end
endmodule
